// ---- design/nand_id_pkg.sv ----
/*
 * constants for the nand identification host controller: wishbone register map,
 * command bytes, address cycle layout, pin timing counts.
 * assumes a 40 MHz system clock and an 8-bit multiplexed nand bus.
 */
package nand_id_pkg;
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DATA = 4'hc;
    // control fields
    localparam int CTRL_GO = 0;
    localparam int CTRL_OP_LO = 1;
    localparam int CTRL_CNT_LO = 8;
    localparam int CTRL_CE = 16;
    localparam int CTRL_WP = 17;
    // operations
    typedef enum logic [2:0]
    {
        OP_CMD = 3'h0,
        OP_ADDR5 = 3'h1,
        OP_READ = 3'h2,
        OP_READ_ID = 3'h3,
        OP_PARAM = 3'h4
    } op_e;
    // command bytes
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_PARAM = 8'hec;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam logic [7:0] CMD_DUMMY = 8'h00;
    localparam logic [7:0] ADDR_ZERO = 8'h00;
    // address cycle layout
    localparam int COL_W = 12;
    localparam int ROW_W = 20;
    localparam int ADDR_CYCLES = 5;
    localparam logic [3:0] HI_NIB_LOW = 4'h0;
    // pin timing: strobe low and high phases, ns
    localparam int CLK_NS = 25;
    localparam int STROBE_NS = 50;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_WAIT_NS = 200;
    localparam int BUSY_WAIT_CYC = (BUSY_WAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : nand_id_pkg

// ---- design/nand_id_host.sv ----
/*
 * host controller driving a stacked nand device for addressing, id and parameter page reads.
 * assumes a classic wishbone master and a nand device whose pins are synchronous to CLOCK.
 */
// Summary of operation
// R1 - two column cycles first, low byte first, then three row cycles
// R2 - row bits 5:0 in cycle three select the page in the block
// R3 - address bit 18 is plane select or low block bit
// R4 - row is block, plane and page bits concatenated, block on top
// R5 - top block bit picks die halves in the four die stack
// R6 - host drives lines 7:4 low in cycles two and five
// R7 - device returns status of one earlier operation per die or plane
// R8 - each die of the stack runs its own operation
// R9 - command 90h plus address 00h enters identification mode
// R10 - host writes dummy command 00h after id before status read
// R11 - five read strobes return maker, device and three more bytes
// R12 - device stays in id mode until another command
// R13 - fifth id byte encodes ecc, plane count and plane size
// R14 - command ECh plus address 00h starts parameter page read
// R15 - device stays in parameter page mode until another command
// R16 - host issues reset before every parameter page read
// R17 - parameter bytes 0 to 3 carry the signature
// R18 - parameter bytes 4 and 5 declare interface version
// R19 - bytes 6 and 7 list supported features
// R20 - bytes 8 and 9 list optional commands
// R21 - command or address latched on write strobe rising edge
// R22 - each read strobe fall gives next byte
// R23 - reserved parameter bytes 10 to 31 read as zero
`timescale 1ns/1ps
module nand_id_host
#(
    parameter int STROBE_CYC = nand_id_pkg::STROBE_CYC,
    parameter int BUSY_WAIT_CYC = nand_id_pkg::BUSY_WAIT_CYC
)
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // nand pins
    input wire logic [7:0] IO_I,
    output logic [7:0] IO_O,
    output logic IO_OE,
    output logic CLE,
    output logic ALE,
    output logic CE_N,
    output logic WE_N,
    output logic RE_N,
    output logic WP_N,
    input wire logic RB_N
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        S_IDLE = 3'h0,
        S_SETUP = 3'h1,
        S_LOW = 3'h2,
        S_HIGH = 3'h3,
        S_WAIT = 3'h4
    } state_e;
    state_e state_r;
    logic [31:0] ctrl_r;
    logic [31:0] addr_r;
    logic [31:0] rdata_r;
    logic [3:0] phase_r;
    logic [7:0] left_r;
    logic [2:0] acyc_r;
    logic [7:0] timer_r;
    logic busy_r, id_seen_r, ce_n_r;
    logic done_r;
    logic ack_r;
    logic [31:0] dat_o_r;
    logic [7:0] io_r;
    logic io_oe_r, cle_r, ale_r, we_n_r, re_n_r;
    // byte for each of the five address cycles; high nibbles of cycles two and five forced low
    function automatic logic [7:0] addr_byte(input logic [31:0] a, input logic [2:0] n);
        case (n)
            // R1 column low byte first
            3'h0: addr_byte = a[7:0];
            // R6 upper lines low
            3'h1: addr_byte = {nand_id_pkg::HI_NIB_LOW, a[11:8]};
            // R2 page then plane then block
            3'h2: addr_byte = a[19:12];
            3'h3: addr_byte = a[27:20];
            // R6 upper lines low, R5 bit 31 on line 3
            3'h4: addr_byte = {nand_id_pkg::HI_NIB_LOW, a[31:28]};
            default: addr_byte = 8'h00;
        endcase
    endfunction : addr_byte
    ////////////////////////////////////////////////////////////////////////////////
    wire bus_req = WB_CYC_I && WB_STB_I && !ack_r;
    wire wr_ctrl = bus_req && WB_WE_I && WB_ADR_I == nand_id_pkg::REG_CTRL && WB_SEL_I[0];
    wire wr_addr = bus_req && WB_WE_I && WB_ADR_I == nand_id_pkg::REG_ADDR;
    wire start = wr_ctrl && WB_DAT_I[nand_id_pkg::CTRL_GO] && !busy_r;
    wire [2:0] op_w = ctrl_r[nand_id_pkg::CTRL_OP_LO +: 3];
    // count and op come from the bus at the start edge, before ctrl_r holds them
    wire [7:0] cnt_w = WB_DAT_I[nand_id_pkg::CTRL_CNT_LO +: 8];
    wire [2:0] op_in = WB_DAT_I[nand_id_pkg::CTRL_OP_LO +: 3];
    // R10 R16 dummy or reset first
    wire pre_cmd = op_in == nand_id_pkg::OP_PARAM || (op_in == nand_id_pkg::OP_CMD && id_seen_r);
    wire [7:0] pre_byte = (op_w == nand_id_pkg::OP_PARAM) ? nand_id_pkg::CMD_RESET : nand_id_pkg::CMD_DUMMY;
    wire [7:0] cmd_w = ctrl_r[31:24];
    wire [31:0] stat_w = {28'h0, RB_N, done_r, busy_r, 1'b0};
    wire [31:0] rd_mux = (WB_ADR_I == nand_id_pkg::REG_CTRL) ? ctrl_r :
                         (WB_ADR_I == nand_id_pkg::REG_ADDR) ? addr_r :
                         (WB_ADR_I == nand_id_pkg::REG_STAT) ? stat_w :
                         (WB_ADR_I == nand_id_pkg::REG_DATA) ? rdata_r : 32'h0;
    wire timer_done = timer_r == 8'h01;
    // phase 4 reset or dummy first, 0 command, 1 address cycles, 2 data reads, 3 finish
    wire is_read_op = op_w == nand_id_pkg::OP_READ || op_w == nand_id_pkg::OP_READ_ID ||
                      op_w == nand_id_pkg::OP_PARAM;
    // R9 R14 single address 00h follows the id or parameter command
    wire single_addr = op_w == nand_id_pkg::OP_READ_ID || op_w == nand_id_pkg::OP_PARAM;
    wire [7:0] cmd_byte = (op_w == nand_id_pkg::OP_READ_ID) ? nand_id_pkg::CMD_READ_ID :
                          (op_w == nand_id_pkg::OP_PARAM) ? nand_id_pkg::CMD_PARAM : cmd_w;
    wire [7:0] addr_out = single_addr ? nand_id_pkg::ADDR_ZERO : addr_byte(addr_r, acyc_r);
    wire last_addr = single_addr || acyc_r == 3'(nand_id_pkg::ADDR_CYCLES - 1);
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            ack_r <= 1'b0;
            dat_o_r <= 32'h0;
            ctrl_r <= 32'h0;
            addr_r <= 32'h0;
            ce_n_r <= 1'b1;
        end
        else
        begin
            ack_r <= bus_req;
            dat_o_r <= rd_mux;
            ce_n_r <= !ctrl_r[nand_id_pkg::CTRL_CE];
            if (wr_ctrl && !busy_r)
                ctrl_r <= WB_DAT_I & ~32'h1;
            if (wr_addr && !busy_r)
                addr_r <= WB_DAT_I;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // strobe engine; each cycle is setup, strobe low, strobe high
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            state_r <= S_IDLE;
            phase_r <= 4'h0;
            left_r <= 8'h0;
            acyc_r <= 3'h0;
            timer_r <= 8'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            id_seen_r <= 1'b0;
            rdata_r <= 32'h0;
            io_r <= 8'h0;
            io_oe_r <= 1'b0;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            we_n_r <= 1'b1;
            re_n_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                S_IDLE:
                begin
                    if (start)
                    begin
                        busy_r <= 1'b1;
                        done_r <= 1'b0;
                        phase_r <= pre_cmd ? 4'h4 : (op_in == nand_id_pkg::OP_READ) ? 4'h2 :
                                   (op_in == nand_id_pkg::OP_ADDR5) ? 4'h1 : 4'h0;
                        acyc_r <= 3'h0;
                        left_r <= cnt_w;
                        id_seen_r <= op_in == nand_id_pkg::OP_READ_ID || (id_seen_r &&
                                     op_in != nand_id_pkg::OP_CMD && op_in != nand_id_pkg::OP_PARAM);
                        state_r <= S_SETUP;
                    end
                    else if (wr_ctrl)
                        done_r <= 1'b0;
                end
                S_SETUP:
                begin
                    // R21 latch selects settle before the write strobe
                    cle_r <= phase_r == 4'h0 || phase_r == 4'h4;
                    ale_r <= phase_r == 4'h1;
                    io_oe_r <= phase_r != 4'h2;
                    io_r <= (phase_r == 4'h4) ? pre_byte : (phase_r == 4'h0) ? cmd_byte : addr_out;
                    timer_r <= 8'(STROBE_CYC);
                    state_r <= S_LOW;
                end
                S_LOW:
                begin
                    we_n_r <= !(phase_r != 4'h2);
                    // R22 read strobe fall advances the device column
                    re_n_r <= !(phase_r == 4'h2);
                    timer_r <= timer_done ? 8'(STROBE_CYC) : timer_r - 8'h01;
                    if (timer_done)
                        state_r <= S_HIGH;
                end
                S_HIGH:
                begin
                    if (!re_n_r)
                        rdata_r <= {rdata_r[23:0], IO_I};
                    // R21 rising write strobe latches the byte
                    we_n_r <= 1'b1;
                    re_n_r <= 1'b1;
                    timer_r <= timer_done ? 8'(BUSY_WAIT_CYC) : timer_r - 8'h01;
                    if (timer_done)
                    begin
                        cle_r <= 1'b0;
                        ale_r <= 1'b0;
                        io_oe_r <= 1'b0;
                        if (phase_r == 4'h0 || phase_r == 4'h4)
                        begin
                            phase_r <= (phase_r == 4'h4) ? 4'h0 : (op_w == nand_id_pkg::OP_CMD) ? 4'h3 : 4'h1;
                            state_r <= (phase_r == 4'h4 || op_w == nand_id_pkg::OP_CMD) ? S_WAIT : S_SETUP;
                        end
                        else if (phase_r == 4'h1)
                        begin
                            acyc_r <= acyc_r + 3'h1;
                            if (last_addr)
                            begin
                                phase_r <= is_read_op ? 4'h2 : 4'h3;
                                state_r <= S_WAIT;
                            end
                            else
                                state_r <= S_SETUP;
                        end
                        else
                        begin
                            left_r <= left_r - 8'h01;
                            state_r <= (left_r <= 8'h01) ? S_WAIT : S_SETUP;
                            phase_r <= (left_r <= 8'h01) ? 4'h3 : phase_r;
                        end
                    end
                end
                S_WAIT:
                begin
                    // settle then wait for ready before command, data or finish
                    if (timer_r != 8'h00)
                        timer_r <= timer_r - 8'h01;
                    else if (RB_N && ((phase_r == 4'h2 && left_r != 8'h00) || phase_r == 4'h0))
                        state_r <= S_SETUP;
                    else if (RB_N)
                    begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_o_r;
    assign IO_O = io_r;
    assign IO_OE = io_oe_r;
    assign CLE = cle_r;
    assign ALE = ale_r;
    assign WE_N = we_n_r;
    assign RE_N = re_n_r;
    assign CE_N = ce_n_r;
    assign WP_N = ctrl_r[nand_id_pkg::CTRL_WP];
    ////////////////////////////////////////////////////////////////////////////////
    // R21 cle and ale never high together, so each latched byte is command or address
    a_cle_ale_excl: assert property (@(posedge CLOCK) disable iff (RST) !(cle_r && ale_r)) // R21
        else $error("cle and ale both high");
    a_we_re_excl: assert property (@(posedge CLOCK) disable iff (RST) !(!we_n_r && !re_n_r)) // R22
        else $error("write and read strobes low together");
    a_addr_hi_low: assert property (@(posedge CLOCK) disable iff (RST)
        (ale_r && !we_n_r && (acyc_r == 3'h1 || acyc_r == 3'h4)) |-> io_r[7:4] == 4'h0) // R6
        else $error("upper lines not low in cycle two or five");
    a_id_cmd: assert property (@(posedge CLOCK) disable iff (RST)
        (cle_r && !we_n_r && op_w == nand_id_pkg::OP_READ_ID) |-> io_r == nand_id_pkg::CMD_READ_ID) // R9
        else $error("id command byte wrong");
    a_param_addr: assert property (@(posedge CLOCK) disable iff (RST)
        (ale_r && !we_n_r && op_w == nand_id_pkg::OP_PARAM) |-> io_r == nand_id_pkg::ADDR_ZERO) // R14
        else $error("parameter address not zero");
    a_col_first: assert property (@(posedge CLOCK) disable iff (RST)
        (ale_r && !we_n_r && acyc_r == 3'h0 && op_w == nand_id_pkg::OP_ADDR5) |-> io_r == addr_r[7:0]) // R1
        else $error("first address cycle not column low");
    a_page_bits: assert property (@(posedge CLOCK) disable iff (RST)
        (ale_r && !we_n_r && acyc_r == 3'h2 && op_w == nand_id_pkg::OP_ADDR5) |-> io_r == addr_r[19:12]) // R2
        else $error("third cycle not page plane block");
    a_rise_hold: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(we_n_r) |-> $past(io_oe_r) && (cle_r || ale_r)) // R21
        else $error("latch select dropped before strobe rise");
    c_read_id: cover property (@(posedge CLOCK) disable iff (RST) done_r && op_w == nand_id_pkg::OP_READ_ID);
    c_param: cover property (@(posedge CLOCK) disable iff (RST) done_r && op_w == nand_id_pkg::OP_PARAM);
    c_addr5: cover property (@(posedge CLOCK) disable iff (RST) $rose(done_r) && op_w == nand_id_pkg::OP_ADDR5);
endmodule : nand_id_host

// ---- tb/nand_dev_model.sv ----
/* behavioural stacked nand device: command and address latch, id and parameter page output, ready/busy.
   assumes host pins change only just after rising edges of clk. */
`timescale 1ns/1ps
module nand_dev_model
#(
    // arbitrary identification bytes, first byte in the top bits
    parameter logic [39:0] ID_BYTES = 40'h1122334455
)
(
    // clock, reset, slow busy select
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    // nand pins
    input wire logic [7:0] bus,
    output logic [7:0] dout,
    input wire logic cle,
    input wire logic ale,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic re_n,
    output logic rb_n,
    // observation
    output logic [39:0] addr_bytes,
    output logic [7:0] last_cmd
);
    logic we_prev, re_prev, reset_seen, valid;
    logic [1:0] mode, hold;
    logic [2:0] aidx;
    logic [5:0] ptr;
    logic [4:0] busy;
    logic [7:0] out_r;
    wire we_rise = !ce_n && !we_prev && we_n;
    //////////////////////////////////////////////////////////////////////
    // parameter page bytes
    function automatic logic [7:0] param_byte(input logic [5:0] i);
        case (i)
            6'h00: return 8'h4f;
            6'h01: return 8'h4e;
            6'h02: return 8'h46;
            6'h03: return 8'h49;
            6'h04: return 8'h02;
            6'h06: return 8'h1e;
            6'h08: return 8'h3b;
            default: return 8'h00;
        endcase
    endfunction : param_byte
    // released bus shows the inverse of the last byte, never a stale match
    assign dout = valid ? out_r : ~out_r;
    assign rb_n = (busy == 5'h00);
    //////////////////////////////////////////////////////////////////////
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            {we_prev, re_prev} <= 2'b11;
            {reset_seen, valid, mode, hold, aidx, ptr, busy, out_r} <= '0;
            addr_bytes <= '0;
            last_cmd <= 8'h00;
        end
        else
        begin
            we_prev <= we_n;
            re_prev <= re_n;
            if (busy != 5'h00)
                busy <= busy - 5'h01;
            // command latch ends any output mode
            if (we_rise && cle)
            begin
                // a status read straight after id is lost
                if (!(mode == 2'h1 && bus == 8'h70))
                    last_cmd <= bus;
                mode <= 2'h0;
                aidx <= 3'h0;
                busy <= slow ? 5'h14 : 5'h02;
                reset_seen <= (bus == 8'hff) | reset_seen;
            end
            if (we_rise && ale)
            begin
                if (aidx < 3'h5)
                    addr_bytes[8*aidx +: 8] <= bus;
                aidx <= aidx + 3'h1;
                ptr <= 6'h00;
                busy <= slow ? 5'h14 : 5'h02;
                if (aidx == 3'h0 && bus == 8'h00 && last_cmd == 8'h90)
                    mode <= 2'h1;
                if (aidx == 3'h0 && bus == 8'h00 && last_cmd == 8'hec)
                begin
                    mode <= reset_seen ? 2'h2 : 2'h3;
                    reset_seen <= 1'b0;
                end
            end
            // read strobe fall gives next byte
            if (!ce_n && re_prev && !re_n)
            begin
                out_r <= (mode == 2'h1 && ptr < 6'h05) ? ID_BYTES[8*(4-int'(ptr)) +: 8] :
                         (mode == 2'h2) ? param_byte(ptr) : 8'h00;
                ptr <= ptr + 6'h01;
                valid <= 1'b1;
                hold <= 2'h0;
            end
            else if (re_n && valid)
            begin
                hold <= hold + 2'h1;
                if (hold == 2'h1)
                    valid <= 1'b0;
            end
            if (ce_n)
                valid <= 1'b0;
        end
    end
endmodule : nand_dev_model

// ---- tb/tb.sv ----
/* self-checking bench for the nand host controller over classic wishbone.
   assumes the device model on the nand pins and a 40 MHz clock. */
`timescale 1ns/1ps
module tb;
    // arbitrary id bytes; the fifth says 1 Gb planes, four planes, 4-bit ecc
    localparam logic [39:0] ID_BYTES = {8'h3c, 8'h7b, 8'h21, 8'h44, 1'h0, 3'h4, 2'h2, 2'h2};
    logic CLOCK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, slow, WB_ACK_O, IO_OE, CLE, ALE, CE_N, WE_N, RE_N, WP_N, RB_N;
    logic [3:0] WB_ADR_I, WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O, q, v;
    logic [7:0] IO_O, dev_io, io_bus, last_cmd;
    logic [39:0] abytes;
    logic [31:0] addrs [2] = '{32'hffff_ffff, 32'h9b2d_6a5c};
    logic [31:0] pp [7] = '{32'h0200_1e00, 32'h3b00_0000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    int err_total = 0;
    int checks = 0;
    assign io_bus = IO_OE ? IO_O : dev_io;
    nand_id_host #(.STROBE_CYC(2), .BUSY_WAIT_CYC(8)) nand_id_host_i (.CLOCK(CLOCK), .RST(RST),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
        .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IO_I(io_bus), .IO_O(IO_O), .IO_OE(IO_OE),
        .CLE(CLE), .ALE(ALE), .CE_N(CE_N), .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N), .RB_N(RB_N));
    nand_dev_model #(.ID_BYTES(ID_BYTES)) nand_dev_model_i (.clk(CLOCK), .rst(RST), .slow(slow), .bus(io_bus),
        .dout(dev_io), .cle(CLE), .ale(ALE), .ce_n(CE_N), .we_n(WE_N), .re_n(RE_N), .rb_n(RB_N),
        .addr_bytes(abytes), .last_cmd(last_cmd));
    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask : check
    // one classic cycle; the leading edge keeps cyc low a cycle between calls
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge CLOCK);
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, a, d};
        n = 0;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (WB_ACK_O !== 1'b1 && n < 100);
        r = WB_DAT_O;
        {WB_CYC_I, WB_STB_I} <= 2'b00;
        if (WB_ACK_O !== 1'b1)
        begin
            err_total++;
            print_verdict();
        end
    endtask : wb
    task automatic run(input logic [2:0] op, input logic [7:0] cnt, input logic [7:0] cmd, input logic wait_done);
        logic [31:0] r;
        int n;
        wb(1'b1, nand_id_pkg::REG_CTRL, {cmd, 6'h00, 2'h3, cnt, 4'h0, op, 1'h1}, r);
        n = 0;
        while (wait_done && n < 500)
        begin
            wb(1'b0, nand_id_pkg::REG_STAT, 32'h0, r);
            if (r[2] === 1'b1)
                break;
            n++;
        end
        if (wait_done && n >= 500)
        begin
            err_total++;
            print_verdict();
        end
    endtask : run
    //////////////////////////////////////////////////////////////////////
    initial
    begin
        {RST, WB_CYC_I, WB_STB_I, WB_WE_I, slow} = 5'h10;
        WB_ADR_I = 4'h0;
        WB_SEL_I = 4'hf;
        WB_DAT_I = 32'h0;
        repeat (12) @(posedge CLOCK);
        RST <= 1'b0;
        check({CE_N, WP_N, WE_N, RE_N, IO_OE, CLE, ALE}, 7'h58);
        wb(1'b0, 4'h6, 32'h0, q);
        check(q, 32'h0);
        foreach (addrs[i])
        begin
            v = addrs[i];
            run(nand_id_pkg::OP_CMD, 8'h00, 8'h00, 1'b1);
            wb(1'b1, nand_id_pkg::REG_ADDR, v, q);
            run(nand_id_pkg::OP_ADDR5, 8'h00, 8'h00, 1'b1);
            check(abytes, {4'h0, v[31:28], v[27:12], 4'h0, v[11:0]});
            check({abytes[35:32], abytes[31:23], abytes[22], abytes[21:16]}, v[31:12]);
        end
        check({CE_N, WP_N}, 2'h1);
        run(nand_id_pkg::OP_CMD, 8'h00, nand_id_pkg::CMD_RESET, 1'b1);
        run(nand_id_pkg::OP_PARAM, 8'h04, 8'h00, 1'b1);
        wb(1'b0, nand_id_pkg::REG_DATA, 32'h0, q);
        check(q, 32'h4f4e_4649);
        foreach (pp[i])
        begin
            run(nand_id_pkg::OP_READ, 8'h04, 8'h00, 1'b1);
            wb(1'b0, nand_id_pkg::REG_DATA, 32'h0, q);
            check(q, pp[i]);
        end
        // slow device: the host has to wait on ready/busy
        slow <= 1'b1;
        run(nand_id_pkg::OP_READ_ID, 8'h04, 8'h00, 1'b1);
        wb(1'b0, nand_id_pkg::REG_DATA, 32'h0, q);
        check(q, ID_BYTES[39:8]);
        run(nand_id_pkg::OP_READ, 8'h01, 8'h00, 1'b1);
        wb(1'b0, nand_id_pkg::REG_DATA, 32'h0, q);
        check(q, ID_BYTES[31:0]);
        run(nand_id_pkg::OP_CMD, 8'h00, 8'h70, 1'b1);
        check(last_cmd, 8'h70);
        run(nand_id_pkg::OP_PARAM, 8'h04, 8'h00, 1'b1);
        wb(1'b0, nand_id_pkg::REG_DATA, 32'h0, q);
        check(q, 32'h4f4e_4649);
        run(nand_id_pkg::OP_CMD, 8'h00, 8'h11, 1'b0);
        wb(1'b0, nand_id_pkg::REG_STAT, 32'h0, q);
        check(q[1], 1'h1);
        run(nand_id_pkg::OP_CMD, 8'h00, 8'h22, 1'b1);
        check(last_cmd, 8'h11);
        print_verdict();
    end
endmodule : tb
